/* frpe_consts.svh */
// Timing, geometry and field constants for the flash range program/erase sequencer
`ifndef FRPE_CONSTS_SVH
`define FRPE_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and bus-cycle rate
// ----------------------------------------------------------------
`define FRPE_CLK_MHZ 40
`define FRPE_BUS_DIV 5
`define FRPE_SPEED_PER_MHZ 4

// ----------------------------------------------------------------
// Program pulse timing, in bus cycles
// ----------------------------------------------------------------
`define FRPE_PROG_CASE1_SPEED 8'h04
`define FRPE_PROG_CASE1_CYC 12'h026
`define FRPE_PROG_MULT 8
`define FRPE_PROG_ADD 12'h005

// ----------------------------------------------------------------
// Erase timing: window in microseconds, target inside the window
// ----------------------------------------------------------------
`define FRPE_ERASE_MIN_US 4000
`define FRPE_ERASE_MAX_US 5500
`define FRPE_ERASE_TARGET_US 4800

// ----------------------------------------------------------------
// Watchdog service timing, in bus cycles
// ----------------------------------------------------------------
`define FRPE_WD_PROG_FIRST 16'h002a
`define FRPE_WD_ERASE_BASE 16'h0033
`define FRPE_WD_ERASE_MULT 3
`define FRPE_WD_PERIOD 16'h0400

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FRPE_ROW_BYTES 32
`define FRPE_PAGE_MASK 16'hffc0
`define FRPE_FIFO_DEPTH 4

`endif

/* frpe_pkg.sv */
// Types shared by the flash range program/erase sequencer
package frpe_pkg;

  // ----------------------------------------------------------------
  // Request kinds and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    FRPE_OP_PROGRAM = 1'b0,
    FRPE_OP_ERASE = 1'b1
  } frpe_op_type;

  typedef enum logic [2:0] {
    FRPE_ST_IDLE = 3'b000,
    FRPE_ST_WAIT_DATA = 3'b001,
    FRPE_ST_PROG = 3'b010,
    FRPE_ST_ERASE = 3'b011,
    FRPE_ST_DONE = 3'b100
  } frpe_state_type;

  // ----------------------------------------------------------------
  // Request carried from the caller
  // ----------------------------------------------------------------
  typedef struct packed {
    frpe_op_type op;
    logic [15:0] index_addr;
    logic [15:0] last_addr;
    logic [7:0] speed_code;
  } frpe_req_type;

  // ----------------------------------------------------------------
  // Commands driven toward the flash array
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic prog;
    logic erase_page;
    logic erase_mass;
  } frpe_flash_type;

endpackage

/* frpe_fifo.sv */
// Small valid/ready FIFO holding write-buffer bytes
`timescale 1ns/100ps
module frpe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // Honest full and empty straight from the occupancy count
  assign in_ready = (count_q != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_ptr_q];

  // Storage written on push only
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule // frpe_fifo

/* frpe_tick_div.sv */
// Divider producing the one-cycle bus-cycle enable
`timescale 1ns/100ps
module frpe_tick_div #(
  parameter int DIV = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Enable output
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_q;

  // Free-running count so bus cycles stay evenly spaced
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick = (cnt_q == CW'(DIV - 1));

endmodule // frpe_tick_div

/* frpe_seq.sv */
// Flash range program and page/array erase sequencer
`include "frpe_consts.svh"
`timescale 1ns/100ps

// Function
// - On program completion the index holds the address after the last byte.
// - Program accepts a full 32-byte row or any shorter range from the buffer.
// - Erase clears one 64-byte page or the entire array.
// - Block-protect register address selects array erase; other addresses erase their page.
// - Erase timing is correct from 1.0 MHz to 8.0 MHz operating frequency.
// - Page and array erase are both held between 4 ms and 5.5 ms.
// - Interrupt mask is set during erase and restored to its entry value.
// - Erase services the watchdog first at 51 plus three times speed code cycles.
// - Erase of protected locations fails and leaves their contents intact.
// - Test high voltage on the interrupt pin bypasses block protection.
// - With protection off or test high voltage present, array erase via block-protect address erases everything.
// - Program with watchdog enabled services it first at 42 bus cycles.
module frpe_seq #(
  parameter int BUS_DIV = `FRPE_BUS_DIV,
  parameter int ERASE_US = `FRPE_ERASE_TARGET_US,
  parameter int FIFO_DEPTH = `FRPE_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Request from the caller
  input wire logic req_valid,
  output logic req_ready,
  input wire frpe_pkg::frpe_req_type req,
  // Write-buffer byte stream
  input wire logic wbuf_valid,
  output logic wbuf_ready,
  input wire logic [7:0] wbuf_data,
  // Protection and environment
  input wire logic [15:0] block_protect_register,
  input wire logic protect_en,
  input wire logic [15:0] protect_start,
  input wire logic test_high_voltage,
  input wire logic watchdog_en,
  input wire logic int_mask_in,
  // Flash array command
  output frpe_pkg::frpe_flash_type flash,
  // Results to the caller
  output logic int_mask_out,
  output logic watchdog_service,
  output logic [15:0] index_out,
  output logic erase_refused,
  output logic done
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int ERASE_PER_CODE = ERASE_US / `FRPE_SPEED_PER_MHZ;

  frpe_pkg::frpe_state_type state_q;
  frpe_pkg::frpe_op_type op_q;
  logic bus_tick;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;
  logic [15:0] index_q;
  logic [15:0] last_q;
  logic [7:0] speed_q;
  logic [23:0] timer_q;
  logic [11:0] prog_len;
  logic [23:0] erase_len;
  logic is_mass;
  logic blocked;
  logic wd_active_q;
  logic [15:0] wd_cnt_q;
  logic [15:0] wd_first_q;
  logic wd_seen_first_q;
  logic [15:0] wd_target;
  logic accept;

  // ----------------------------------------------------------------
  // Bus-cycle enable and write buffer
  // ----------------------------------------------------------------
  frpe_tick_div #(
    .DIV(BUS_DIV)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .tick(bus_tick)
  );

  // Buffer stalls the source only when all FIFO_DEPTH entries are full
  frpe_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(wbuf_valid),
    .in_ready(wbuf_ready),
    .in_data(wbuf_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  assign req_ready = (state_q == frpe_pkg::FRPE_ST_IDLE);
  assign accept = req_valid && req_ready;
  assign fifo_pop = (state_q == frpe_pkg::FRPE_ST_WAIT_DATA) && fifo_valid;

  // Program pulse length follows the speed code, with a floor at the slowest case
  always_comb begin
    if (speed_q <= `FRPE_PROG_CASE1_SPEED) begin
      prog_len = `FRPE_PROG_CASE1_CYC;
    end else begin
      prog_len = 12'(speed_q * `FRPE_PROG_MULT) + `FRPE_PROG_ADD;
    end
  end

  // Erase hold scales with the code so wall time stays inside the window
  assign erase_len = 24'(ERASE_PER_CODE) * 24'(speed_q);

  // Array erase when the index names the block-protect register
  assign is_mass = (index_q == block_protect_register);

  // Protection check, bypassed by the test high voltage
  always_comb begin
    if (test_high_voltage || !protect_en) begin
      blocked = 1'b0;
    end else if (is_mass) begin
      blocked = 1'b1;
    end else begin
      blocked = ((index_q & `FRPE_PAGE_MASK) >= (protect_start & `FRPE_PAGE_MASK));
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  // One byte per pass keeps watchdog service independent of range size
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= frpe_pkg::FRPE_ST_IDLE;
      timer_q <= '0;
    end else begin
      case (state_q)
        frpe_pkg::FRPE_ST_IDLE: begin
          if (accept) begin
            state_q <= (req.op == frpe_pkg::FRPE_OP_PROGRAM) ?
                       frpe_pkg::FRPE_ST_WAIT_DATA : frpe_pkg::FRPE_ST_ERASE;
            timer_q <= '0;
          end
        end
        frpe_pkg::FRPE_ST_WAIT_DATA: begin
          if (fifo_valid) begin
            state_q <= frpe_pkg::FRPE_ST_PROG;
            timer_q <= '0;
          end
        end
        frpe_pkg::FRPE_ST_PROG: begin
          if (bus_tick) begin
            if (timer_q == 24'(prog_len) - 24'h000001) begin
              timer_q <= '0;
              state_q <= (index_q == last_q) ?
                         frpe_pkg::FRPE_ST_DONE : frpe_pkg::FRPE_ST_WAIT_DATA;
            end else begin
              timer_q <= timer_q + 24'h000001;
            end
          end
        end
        frpe_pkg::FRPE_ST_ERASE: begin
          if (blocked) begin
            state_q <= frpe_pkg::FRPE_ST_DONE;
          end else if (bus_tick) begin
            if (timer_q == erase_len - 24'h000001) begin
              state_q <= frpe_pkg::FRPE_ST_DONE;
            end else begin
              timer_q <= timer_q + 24'h000001;
            end
          end
        end
        frpe_pkg::FRPE_ST_DONE: begin
          state_q <= frpe_pkg::FRPE_ST_IDLE;
        end
        default: begin
          state_q <= frpe_pkg::FRPE_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request parameters and index advance
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= frpe_pkg::FRPE_OP_PROGRAM;
      index_q <= '0;
      last_q <= '0;
      speed_q <= '0;
    end else if (accept) begin
      op_q <= req.op;
      index_q <= req.index_addr;
      last_q <= req.last_addr;
      speed_q <= req.speed_code;
    end else if (state_q == frpe_pkg::FRPE_ST_PROG && bus_tick &&
                 timer_q == 24'(prog_len) - 24'h000001) begin
      index_q <= index_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Flash array command outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash <= '0;
    end else begin
      flash.prog <= 1'b0;
      flash.erase_page <= 1'b0;
      flash.erase_mass <= 1'b0;
      if (fifo_pop) begin
        flash.addr <= index_q;
        flash.wdata <= fifo_data;
      end
      if (state_q == frpe_pkg::FRPE_ST_PROG) begin
        flash.prog <= !(bus_tick && timer_q == 24'(prog_len) - 24'h000001);
      end
      if (state_q == frpe_pkg::FRPE_ST_ERASE && !blocked) begin
        flash.addr <= index_q & `FRPE_PAGE_MASK;
        flash.erase_page <= !is_mass && !(bus_tick && timer_q == erase_len - 24'h000001);
        flash.erase_mass <= is_mass && !(bus_tick && timer_q == erase_len - 24'h000001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask
  // ----------------------------------------------------------------
  // Mask forced on while busy; idle hands the caller's own bit back untouched
  assign int_mask_out = (state_q == frpe_pkg::FRPE_ST_IDLE) ? int_mask_in : 1'b1;

  // ----------------------------------------------------------------
  // Watchdog service, counted in bus cycles from the call
  // ----------------------------------------------------------------
  assign wd_target = wd_seen_first_q ? `FRPE_WD_PERIOD : wd_first_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wd_active_q <= 1'b0;
      wd_cnt_q <= '0;
      wd_first_q <= '0;
      wd_seen_first_q <= 1'b0;
      watchdog_service <= 1'b0;
    end else begin
      watchdog_service <= 1'b0;
      if (accept) begin
        wd_cnt_q <= '0;
        wd_seen_first_q <= 1'b0;
        if (req.op == frpe_pkg::FRPE_OP_ERASE) begin
          wd_active_q <= 1'b1;
          wd_first_q <= `FRPE_WD_ERASE_BASE + 16'(req.speed_code * `FRPE_WD_ERASE_MULT);
        end else begin
          wd_active_q <= watchdog_en;
          wd_first_q <= `FRPE_WD_PROG_FIRST;
        end
      end else if (state_q == frpe_pkg::FRPE_ST_DONE) begin
        wd_active_q <= 1'b0;
      end else if (wd_active_q && bus_tick) begin
        if (wd_cnt_q == wd_target - 16'h0001) begin
          wd_cnt_q <= '0;
          wd_seen_first_q <= 1'b1;
          watchdog_service <= 1'b1;
        end else begin
          wd_cnt_q <= wd_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion and results
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      erase_refused <= 1'b0;
      index_out <= '0;
    end else begin
      done <= (state_q == frpe_pkg::FRPE_ST_DONE);
      if (state_q == frpe_pkg::FRPE_ST_DONE) begin
        index_out <= index_q;
        erase_refused <= (op_q == frpe_pkg::FRPE_OP_ERASE) && blocked;
      end
    end
  end

endmodule // frpe_seq

/* frpe_seq_asserts.sv */
// Concurrent checks on the ports of the flash range program/erase sequencer
`timescale 1ns/100ps
module frpe_seq_asserts #(
  parameter int BUS_DIV = 5,
  parameter int ERASE_US = 4800,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Request and write buffer
  input wire logic req_valid,
  input wire logic req_ready,
  input wire frpe_pkg::frpe_req_type req,
  input wire logic wbuf_valid,
  input wire logic wbuf_ready,
  input wire logic [7:0] wbuf_data,
  // Protection and environment
  input wire logic [15:0] block_protect_register,
  input wire logic protect_en,
  input wire logic [15:0] protect_start,
  input wire logic test_high_voltage,
  input wire logic watchdog_en,
  input wire logic int_mask_in,
  // Results
  input wire frpe_pkg::frpe_flash_type flash,
  input wire logic int_mask_out,
  input wire logic watchdog_service,
  input wire logic [15:0] index_out,
  input wire logic erase_refused,
  input wire logic done
);
  // ----------------------------------------------------------------
  // Request capture and erase hold counter
  // ----------------------------------------------------------------
  logic [15:0] cap_index_q;
  logic [7:0] cap_speed_q;
  logic [23:0] ecnt_q;
  logic erasing;
  int hold;
  assign erasing = flash.erase_page | flash.erase_mass;
  // Hold length scales with the speed code; one bus tick plus one cycle of slack each way
  assign hold = (ERASE_US / 4) * int'(cap_speed_q) * BUS_DIV;
  // Keep what was taken so later outputs can be tied back to it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_index_q <= 16'h0000;
      cap_speed_q <= 8'h00;
    end else if (req_valid && req_ready) begin
      cap_index_q <= req.index_addr;
      cap_speed_q <= req.speed_code;
    end
  end
  // Count the cycles the erase condition stands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ecnt_q <= 24'h000000;
    end else begin
      ecnt_q <= erasing ? ecnt_q + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_done_single: assert property (done |=> !done)
    else $error("done stood longer than one cycle");
  a_done_ready: assert property (done |-> req_ready)
    else $error("not idle when done pulsed");
  a_mask_busy: assert property (!req_ready |-> int_mask_out)
    else $error("interrupt mask clear while busy");
  a_mask_restore: assert property (req_ready |-> int_mask_out == int_mask_in)
    else $error("interrupt mask not restored when idle");
  a_erase_exclusive: assert property (!(flash.erase_page && flash.erase_mass))
    else $error("page and array erase together");
  a_mass_select: assert property ($rose(flash.erase_mass) |->
    cap_index_q == block_protect_register)
    else $error("array erase for an ordinary address");
  a_page_select: assert property ($rose(flash.erase_page) |->
    cap_index_q != block_protect_register)
    else $error("page erase for the protect register address");
  a_erase_hold: assert property ($fell(erasing) |->
    int'(ecnt_q) >= hold - BUS_DIV - 1 && int'(ecnt_q) <= hold + BUS_DIV + 1)
    else $error("erase hold length wrong");
  a_prog_busy: assert property (flash.prog |-> !req_ready && !erasing)
    else $error("program pulse outside a program request");
  a_refused_done: assert property ($rose(erase_refused) |-> done)
    else $error("erase refusal raised away from done");
endmodule // frpe_seq_asserts

bind frpe_seq frpe_seq_asserts #(.BUS_DIV(BUS_DIV), .ERASE_US(ERASE_US))
  u_asserts (.clock(clock), .rst_n(rst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .wbuf_valid(wbuf_valid),
  .wbuf_ready(wbuf_ready), .wbuf_data(wbuf_data),
  .block_protect_register(block_protect_register), .protect_en(protect_en),
  .protect_start(protect_start), .test_high_voltage(test_high_voltage),
  .watchdog_en(watchdog_en), .int_mask_in(int_mask_in), .flash(flash),
  .int_mask_out(int_mask_out), .watchdog_service(watchdog_service),
  .index_out(index_out), .erase_refused(erase_refused), .done(done));

/* frpe_flash_model.sv */
// Behavioural flash array answering the sequencer's commands
`include "frpe_consts.svh"
`timescale 1ns/100ps
module frpe_flash_model (
  // Clock
  input wire logic clock,
  // Commands from the sequencer
  input wire frpe_pkg::frpe_flash_type flash
);
  // ----------------------------------------------------------------
  // Sparse array: an absent byte reads as erased
  // ----------------------------------------------------------------
  logic [7:0] mem [logic [15:0]];
  logic [15:0] keys [$];
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // Commands act every cycle they stand, so repeats are harmless
  always @(posedge clock) begin
    if (flash.prog) begin
      mem[flash.addr] = flash.wdata;
    end
    if (flash.erase_mass) begin
      mem.delete();
    end
    if (flash.erase_page) begin
      keys.delete();
      foreach (mem[a]) begin
        if ((a & `FRPE_PAGE_MASK) == (flash.addr & `FRPE_PAGE_MASK)) keys.push_back(a);
      end
      foreach (keys[i]) mem.delete(keys[i]);
    end
  end
endmodule // frpe_flash_model

/* frpe_seq_bench.sv */
// Self-checking bench for the flash range program/erase sequencer
`timescale 1ns/100ps
module frpe_seq_bench;
  // ----------------------------------------------------------------
  // Sizes and signals
  // ----------------------------------------------------------------
  localparam int BUS_DIV = 1;
  localparam int ERASE_US = 200;
  // Register address that selects array erase; the value is arbitrary
  logic [15:0] prot_reg = 16'hfe10;
  logic [15:0] prot_start = 16'he000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  frpe_pkg::frpe_req_type req = '0;
  logic wbuf_valid = 1'b0;
  logic [7:0] wbuf_data = 8'h00;
  logic protect_en = 1'b0;
  logic test_high_voltage = 1'b0;
  logic watchdog_en = 1'b1;
  logic int_mask_in = 1'b0;
  logic req_ready;
  logic wbuf_ready;
  frpe_pkg::frpe_flash_type flash;
  logic int_mask_out;
  logic watchdog_service;
  logic [15:0] index_out;
  logic erase_refused;
  logic done;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int wd_at;

  frpe_seq #(.BUS_DIV(BUS_DIV), .ERASE_US(ERASE_US)) u_dut (
    .clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .wbuf_valid(wbuf_valid), .wbuf_ready(wbuf_ready), .wbuf_data(wbuf_data),
    .block_protect_register(prot_reg), .protect_en(protect_en),
    .protect_start(prot_start), .test_high_voltage(test_high_voltage),
    .watchdog_en(watchdog_en), .int_mask_in(int_mask_in), .flash(flash),
    .int_mask_out(int_mask_out), .watchdog_service(watchdog_service),
    .index_out(index_out), .erase_refused(erase_refused), .done(done));
  frpe_flash_model u_flash (.clock(clock), .flash(flash));

  // 25 ns period
  always #12.5 clock = ~clock;
  // Hang guard: all tests need well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      $display("BAD cycles expected below %0d seen %0d", 30000, cycles);
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Offer bytes back to back; each one held until the FIFO takes it
  task automatic push_bytes(input int n, input logic [7:0] base);
    for (int k = 0; k < n; k++) begin
      wbuf_valid <= 1'b1;
      wbuf_data <= base + 8'(k);
      do @(posedge clock); while (wbuf_ready !== 1'b1);
    end
    wbuf_valid <= 1'b0;
  endtask
  // Request held until taken, then wait for done and note the first watchdog pulse
  task automatic run_req(input frpe_pkg::frpe_op_type op, input logic [15:0] idx,
      input logic [15:0] last, input logic [7:0] spd);
    int n;
    n = 0;
    wd_at = -1;
    req_valid <= 1'b1;
    req <= '{op: op, index_addr: idx, last_addr: last, speed_code: spd};
    do @(posedge clock); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do begin
      @(posedge clock);
      n++;
      if (watchdog_service === 1'b1 && wd_at < 0) wd_at = n;
    end while (done !== 1'b1 && n < 5000);
    cmp_bit("done", 1'b1, done);
  endtask
  task automatic wd_near(input int exp);
    cmp_bit("watchdog first", 1'b1, wd_at >= exp - 1 && wd_at <= exp + 2);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Full row while the FIFO refills under the running program
  task automatic t_row();
    fork
      push_bytes(32, 8'h40);
      run_req(frpe_pkg::FRPE_OP_PROGRAM, 16'hc000, 16'hc01f, 8'h0a);
    join
    cmp_val("index row", 16'hc020, index_out);
    cmp_val("byte c000", 16'h0040, {8'h00, u_flash.rd(16'hc000)});
    cmp_val("byte c01f", 16'h005f, {8'h00, u_flash.rd(16'hc01f)});
    wd_near(42);
    $display("test row program done");
  endtask
  // Fill the FIFO until it refuses, then a short range drains it
  task automatic t_short();
    watchdog_en <= 1'b0;
    push_bytes(4, 8'h55);
    @(posedge clock);
    cmp_bit("fifo full", 1'b0, wbuf_ready);
    run_req(frpe_pkg::FRPE_OP_PROGRAM, 16'he004, 16'he007, 8'h04);
    cmp_val("index short", 16'he008, index_out);
    cmp_val("byte e004", 16'h0055, {8'h00, u_flash.rd(16'he004)});
    cmp_val("byte e007", 16'h0058, {8'h00, u_flash.rd(16'he007)});
    cmp_bit("fifo drained", 1'b1, wbuf_ready);
    cmp_bit("no watchdog", 1'b1, wd_at < 0);
    watchdog_en <= 1'b1;
    $display("test short program done");
  endtask
  // Page erase from an address inside the page
  task automatic t_page();
    run_req(frpe_pkg::FRPE_OP_ERASE, 16'hc021, 16'h0000, 8'h0e);
    cmp_val("page c000", 16'h00ff, {8'h00, u_flash.rd(16'hc000)});
    cmp_val("page c01f", 16'h00ff, {8'h00, u_flash.rd(16'hc01f)});
    cmp_val("other page", 16'h0055, {8'h00, u_flash.rd(16'he004)});
    cmp_bit("not refused", 1'b0, erase_refused);
    cmp_bit("mask idle", 1'b0, int_mask_out);
    wd_near(51 + 3 * 14);
    $display("test page erase done");
  endtask
  // Protected page refused, then test voltage lets it through
  task automatic t_protect();
    protect_en <= 1'b1;
    run_req(frpe_pkg::FRPE_OP_ERASE, 16'he004, 16'h0000, 8'h08);
    cmp_bit("refused", 1'b1, erase_refused);
    cmp_val("kept e004", 16'h0055, {8'h00, u_flash.rd(16'he004)});
    test_high_voltage <= 1'b1;
    run_req(frpe_pkg::FRPE_OP_ERASE, 16'he004, 16'h0000, 8'h08);
    cmp_bit("bypass", 1'b0, erase_refused);
    cmp_val("gone e004", 16'h00ff, {8'h00, u_flash.rd(16'he004)});
    prot_start <= 16'hf000;
    test_high_voltage <= 1'b0;
    run_req(frpe_pkg::FRPE_OP_ERASE, 16'he004, 16'h0000, 8'h08);
    cmp_bit("below start", 1'b0, erase_refused);
    protect_en <= 1'b0;
    test_high_voltage <= 1'b0;
    $display("test protection done");
  endtask
  // Array erase at both ends of the speed range, entered with the mask set
  task automatic t_mass();
    logic [7:0] spds [2];
    spds = '{8'h04, 8'h20};
    int_mask_in <= 1'b1;
    foreach (spds[i]) begin
      fork
        push_bytes(1, 8'h3c);
        run_req(frpe_pkg::FRPE_OP_PROGRAM, 16'hc100, 16'hc100, spds[i]);
      join
      run_req(frpe_pkg::FRPE_OP_ERASE, prot_reg, 16'h0000, spds[i]);
      cmp_val("array c100", 16'h00ff, {8'h00, u_flash.rd(16'hc100)});
      cmp_bit("mask restored", 1'b1, int_mask_out);
    end
    int_mask_in <= 1'b0;
    $display("test array erase done");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_row();
    t_short();
    t_page();
    t_protect();
    t_mass();
    final_report();
  end
endmodule // frpe_seq_bench
